// *** sdc_top.sv ***
// Conversion sequencer, register file and result handling
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module sdc_top #(
  parameter int CNT_W   = 12,
  parameter int F_SHIFT = 13,
  parameter int S_SHIFT = 11
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_arst_n,
  input  wire logic [sdc_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [sdc_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic [sdc_pkg::DATA_W-1:0]       o_rdata,
  input  wire logic                        i_mod_data,
  input  wire logic                        i_cal_err,
  output logic                             o_busy,
  output logic                             o_done,
  output logic                             o_adc_en,
  output logic                             o_burnout_en,
  output logic [2:0]                       o_pga_gain,
  output logic                             o_vref_ext,
  output sdc_pkg::sdc_dac_t                o_dac,
  output logic                             o_dac_load
);
  import sdc_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } sdc_state_t;

  // Reset release and modulator input synchronisers
  logic rst_q1;
  logic rst_n;
  logic mod_q1;
  logic mod_q2;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_q1 <= 1'b0;
      mod_q2 <= 1'b0;
    end else begin
      mod_q1 <= i_mod_data;
      mod_q2 <= mod_q1;
    end
  end

  // Registers
  logic [7:0]       ctrl_reg;
  logic [7:0]       cfg_reg;
  logic [7:0]       mode_reg;
  logic [7:0]       stat_reg;
  logic [7:0]       dac_reg;
  logic [7:0]       clkdiv_reg;
  logic [7:0]       dech_reg;
  logic [7:0]       decl_reg;
  logic [RES_W-1:0] slow_reg;
  logic [RES_W-1:0] fast_reg;
  sdc_state_t       state_reg;

  logic             idle;
  logic             wr_ctrl;
  logic             wr_cfg;
  logic             wr_mode;
  logic             wr_stat;
  logic             wr_dac;
  logic             wr_clk;
  logic             wr_dech;
  logic             wr_decl;
  sdc_mode_t        sm;
  logic             conv_req;
  logic             start;
  logic             abort;
  logic             sel_valid;
  logic             single_end;

  assign idle    = (state_reg == ST_IDLE);
  assign wr_ctrl = i_wr & (i_addr == A_CTRL);
  assign wr_cfg  = i_wr & (i_addr == A_CFG);
  assign wr_mode = i_wr & (i_addr == A_MODE);
  assign wr_stat = i_wr & (i_addr == A_STAT);
  assign wr_dac  = i_wr & (i_addr == A_DAC);
  assign wr_clk  = i_wr & (i_addr == A_CLKDIV);
  assign wr_dech = i_wr & (i_addr == A_DECH);
  assign wr_decl = i_wr & (i_addr == A_DECL);
  assign sm      = sdc_mode_t'(mode_reg[2:0]);

  // Calibration codes are accepted but sequenced elsewhere
  assign conv_req = mode_reg[B_EN] & ((sm == SDC_SM_SINGLE) | (sm == SDC_SM_CONT));
  assign start    = idle & conv_req & ~wr_mode;
  assign abort    = ~idle & wr_mode;

  // Settings only change while idle so a running conversion stays coherent
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RST;
      cfg_reg  <= ZERO8;
    end else if (idle) begin
      if (wr_ctrl) begin
        ctrl_reg <= i_wdata & CTRL_MASK;
      end
      if (wr_cfg) begin
        cfg_reg <= i_wdata & CFG_MASK;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_reg    <= ZERO8;
      o_dac_load <= 1'b0;
    end else begin
      o_dac_load <= wr_dac & idle;
      if (wr_dac && idle) begin
        dac_reg <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkdiv_reg <= ZERO8;
      dech_reg   <= DECH_RST;
      decl_reg   <= DECL_RST;
    end else if (idle) begin
      if (wr_clk) begin
        clkdiv_reg <= i_wdata;
      end
      if (wr_dech) begin
        dech_reg <= i_wdata & DECH_RST;
      end
      if (wr_decl) begin
        decl_reg <= i_wdata;
      end
    end
  end

  // Mode: software write wins over hardware return to idle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= ZERO8;
    end else if (wr_mode) begin
      mode_reg <= i_wdata & MODE_MASK;
    end else if (!mode_reg[B_EN]) begin
      mode_reg[2:0] <= SDC_SM_IDLE;
    end else if (single_end) begin
      mode_reg[2:0] <= SDC_SM_IDLE;
    end
  end

  // Sequencer
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (abort || single_end || !conv_req) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign o_busy = ~idle;

  // Modulator clock enable and sample tick
  logic [7:0]        mdiv_reg;
  logic [OSR_W-1:0]  osr_reg;
  logic [DECI_W-1:0] samp_reg;
  logic [DECI_W-1:0] deci_raw;
  logic [DECI_W-1:0] deci_eff;
  logic              md_en;
  logic              tick;
  logic              last;

  assign deci_raw = {dech_reg[2:0], decl_reg};
  assign deci_eff = (deci_raw < DECI_MIN) ? DECI_MIN : deci_raw;
  assign md_en    = ~idle & (mdiv_reg == clkdiv_reg);
  assign tick     = md_en & (osr_reg == OSR_LAST);
  assign last     = (samp_reg == deci_eff);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdiv_reg <= '0;
      osr_reg  <= '0;
      samp_reg <= '0;
    end else if (idle || abort) begin
      mdiv_reg <= '0;
      osr_reg  <= '0;
      samp_reg <= '0;
    end else begin
      mdiv_reg <= md_en ? 8'h00 : mdiv_reg + 8'h01;
      if (md_en) begin
        osr_reg <= osr_reg + OSR_W'(1);
      end
      if (tick) begin
        samp_reg <= last ? '0 : samp_reg + DECI_W'(1);
      end
    end
  end

  // Filters
  logic [CNT_W-1:0] fast_sum;
  sdc_filt_t        fast_out;
  sdc_filt_t        slow_out;
  logic             filt_clear;

  assign filt_clear = idle | abort;

  sdc_fast_filter #(
    .CNT_W (CNT_W),
    .SHIFT (F_SHIFT)
  ) u_fast (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_clear (filt_clear),
    .i_tick  (tick),
    .i_bit   (mod_q2),
    .i_last  (last),
    .i_pol   (ctrl_reg[B_POL]),
    .o_sum   (fast_sum),
    .o_out   (fast_out)
  );

  sdc_sinc3_filter #(
    .CNT_W (CNT_W),
    .SHIFT (S_SHIFT)
  ) u_slow (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_clear (filt_clear),
    .i_valid (fast_out.valid),
    .i_sum   (fast_sum),
    .i_pol   (ctrl_reg[B_POL]),
    .o_out   (slow_out)
  );

  // Result registers update on every result, errors or not
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_reg <= '0;
      fast_reg <= '0;
    end else begin
      if (slow_out.valid) begin
        slow_reg <= slow_out.data;
      end
      if (fast_out.valid) begin
        fast_reg <= fast_out.data;
      end
    end
  end

  // Selected filter decides completion
  assign sel_valid  = cfg_reg[B_ISEL] ? fast_out.valid : slow_out.valid;
  assign single_end = ~idle & ~wr_mode & sel_valid & (sm == SDC_SM_SINGLE);

  // Sticky flags, write zero to clear; a set in the same cycle wins
  logic [7:0] set_vec;
  logic [7:0] clr_keep;
  logic       ovr_ev;

  assign ovr_ev = sel_valid & stat_reg[B_DONE];

  always_comb begin
    set_vec          = ZERO8;
    set_vec[B_DONE]  = sel_valid;
    set_vec[B_OVR]   = ovr_ev;
    set_vec[B_S3C]   = slow_out.valid & slow_out.clip;
    set_vec[B_FFC]   = fast_out.valid & fast_out.clip;
    set_vec[B_ERR]   = ovr_ev | set_vec[B_S3C] | set_vec[B_FFC] | i_cal_err;
  end

  assign clr_keep = wr_stat ? (i_wdata | ~FLAG_MASK) : 8'hFF;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= ZERO8;
    end else begin
      stat_reg <= ((stat_reg & clr_keep) | set_vec) & FLAG_MASK;
    end
  end

  assign o_done = stat_reg[B_DONE];

  // Register read, data one cycle after the strobe
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = ZERO8;
    unique case (i_addr)
      A_CTRL:   rd_mux = ctrl_reg;
      A_CFG:    rd_mux = cfg_reg;
      A_MODE:   rd_mux = mode_reg;
      A_STAT:   rd_mux = stat_reg | (8'(o_busy) << B_BUSY);
      A_DAC:    rd_mux = dac_reg;
      A_CLKDIV: rd_mux = clkdiv_reg;
      A_DECH:   rd_mux = dech_reg;
      A_DECL:   rd_mux = decl_reg;
      A_SLOW_H: rd_mux = slow_reg[23:16];
      A_SLOW_M: rd_mux = slow_reg[15:8];
      A_SLOW_L: rd_mux = slow_reg[7:0];
      A_FAST_H: rd_mux = fast_reg[23:16];
      A_FAST_M: rd_mux = fast_reg[15:8];
      A_FAST_L: rd_mux = fast_reg[7:0];
      default:  rd_mux = ZERO8;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= ZERO8;
    end else begin
      o_rdata <= i_rd ? rd_mux : ZERO8;
    end
  end

  // Analog control outputs
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_adc_en     <= 1'b0;
      o_burnout_en <= 1'b0;
      o_pga_gain   <= 3'h0;
      o_vref_ext   <= 1'b0;
      o_dac        <= '0;
    end else begin
      o_adc_en     <= mode_reg[B_EN];
      o_burnout_en <= ctrl_reg[B_BURNOUT];
      o_pga_gain   <= ctrl_reg[2:0];
      o_vref_ext   <= cfg_reg[B_VREF];
      o_dac.sign   <= dac_reg[B_DAC_SIGN];
      o_dac.mag    <= dac_reg[6:0];
    end
  end

endmodule : sdc_top

// *** sdc_pkg.sv ***
// Constants, register map and carrier types for the sigma-delta conversion control
// Operation
// - Writing the single code starts one conversion for the selected filter
// - Busy flag stays 1 throughout any single or continuous conversion
// - Fast filter result comes after one conversion period
// - First slow filter result comes only after three conversion periods
// - Select bit 1 flags done on fast result, 0 on slow result
// - Single conversion ends by returning mode to idle and clearing busy
// - Single slow conversion also yields a valid fast result
// - Continuous mode restarts conversions back to back until mode changes
// - Continuous: fast result every period, slow from third period onward
// - Each filter updates its own result register on every new result
// - Separate three-byte result registers for slow and fast filters
// - Slow filter combines last three periods, fast uses current only
// - Polarity 0 gives straight binary output coding
// - Polarity 1 gives two's complement output coding
// - Slow filter internal overflow sets the slow clip flag
// - Fast filter internal overflow sets the fast clip flag
// - Result arriving while done flag set raises overrun, data overwritten
// - Error flag set on either clip, overrun or calibration limit
// - Result registers written at every conversion end, errors or not
// - Offset DAC byte is sign-magnitude; every write while idle reloads the DAC, writes while busy are ignored
// - Burnout enable bit switches the burnout current sources
// - Mode codes: 000 idle, 010 single, 011 continuous, others calibration
// - Changing mode during a conversion aborts it; result not valid
package sdc_pkg;

  localparam int RES_W = 24;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int DECI_W = 11;

  // Register offsets
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_CFG    = 4'h1;
  localparam logic [3:0] A_MODE   = 4'h2;
  localparam logic [3:0] A_STAT   = 4'h3;
  localparam logic [3:0] A_DAC    = 4'h4;
  localparam logic [3:0] A_CLKDIV = 4'h5;
  localparam logic [3:0] A_DECH   = 4'h6;
  localparam logic [3:0] A_DECL   = 4'h7;
  localparam logic [3:0] A_SLOW_H = 4'h8;
  localparam logic [3:0] A_SLOW_M = 4'h9;
  localparam logic [3:0] A_SLOW_L = 4'hA;
  localparam logic [3:0] A_FAST_H = 4'hB;
  localparam logic [3:0] A_FAST_M = 4'hC;
  localparam logic [3:0] A_FAST_L = 4'hD;

  // Field positions
  localparam int B_POL     = 4;
  localparam int B_BURNOUT = 3;
  localparam int B_ISEL    = 4;
  localparam int B_VREF    = 2;
  localparam int B_EN      = 7;
  localparam int B_DONE    = 0;
  localparam int B_ERR     = 1;
  localparam int B_OVR     = 2;
  localparam int B_S3C     = 3;
  localparam int B_FFC     = 4;
  localparam int B_BUSY    = 7;
  localparam int B_DAC_SIGN = 7;

  // Write masks and reset values
  localparam logic [7:0] CTRL_MASK  = 8'h1F;
  localparam logic [7:0] CFG_MASK   = 8'h14;
  localparam logic [7:0] MODE_MASK  = 8'h87;
  localparam logic [7:0] FLAG_MASK  = 8'h1F;
  localparam logic [7:0] CTRL_RST   = 8'h10;
  localparam logic [7:0] ZERO8      = 8'h00;
  localparam logic [7:0] DECH_RST   = 8'h07;
  localparam logic [7:0] DECL_RST   = 8'hFF;
  localparam logic [DECI_W-1:0] DECI_MIN = 11'h013;

  // Modulator samples once per this many modulator clocks
  localparam int OSR_W = 7;
  localparam logic [OSR_W-1:0] OSR_LAST = 7'h7F;

  // Slow filter needs this many periods before its first result
  localparam logic [1:0] SLOW_FILL = 2'h2;

  localparam logic [RES_W-1:0] SIGN_BIT = 24'h800000;

  typedef enum logic [2:0] {
    SDC_SM_IDLE   = 3'b000,
    SDC_SM_CALALL = 3'b001,
    SDC_SM_SINGLE = 3'b010,
    SDC_SM_CONT   = 3'b011,
    SDC_SM_CAL_IO = 3'b100,
    SDC_SM_CAL_IG = 3'b101,
    SDC_SM_CAL_SO = 3'b110,
    SDC_SM_CAL_SG = 3'b111
  } sdc_mode_t;

  typedef struct packed {
    logic             valid;
    logic             clip;
    logic [RES_W-1:0] data;
  } sdc_filt_t;

  typedef struct packed {
    logic       sign;
    logic [6:0] mag;
  } sdc_dac_t;

endpackage : sdc_pkg

// *** sdc_fast_filter.sv ***
// Single-period decimation filter: counts modulator ones over one period
`timescale 1ns/1ps
module sdc_fast_filter #(
  parameter int CNT_W = 12,
  parameter int SHIFT = 13
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clear,
  input  wire logic             i_tick,
  input  wire logic             i_bit,
  input  wire logic             i_last,
  input  wire logic             i_pol,
  output logic [CNT_W-1:0]      o_sum,
  output sdc_pkg::sdc_filt_t    o_out
);
  import sdc_pkg::*;

  localparam int SC_W = CNT_W + SHIFT;

  logic [CNT_W-1:0] acc_reg;
  logic [CNT_W-1:0] sum_next;
  logic [SC_W-1:0]  scaled;
  logic             clip;
  logic [RES_W-1:0] sat;

  assign sum_next = acc_reg + CNT_W'(i_bit);
  assign scaled   = {sum_next, {SHIFT{1'b0}}};
  assign clip     = |scaled[SC_W-1:RES_W];
  assign sat      = clip ? {RES_W{1'b1}} : scaled[RES_W-1:0];

  // Only the current period contributes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg <= '0;
    end else if (i_clear) begin
      acc_reg <= '0;
    end else if (i_tick) begin
      acc_reg <= i_last ? '0 : sum_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out <= '0;
      o_sum <= '0;
    end else begin
      o_out.valid <= i_tick & i_last & ~i_clear;
      if (i_tick && i_last && !i_clear) begin
        o_sum      <= sum_next;
        o_out.clip <= clip;
        o_out.data <= i_pol ? (sat ^ SIGN_BIT) : sat;
      end
    end
  end

endmodule : sdc_fast_filter

// *** sdc_sinc3_filter.sv ***
// Three-period weighted decimation filter fed with per-period counts
`timescale 1ns/1ps
module sdc_sinc3_filter #(
  parameter int CNT_W = 12,
  parameter int SHIFT = 11
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clear,
  input  wire logic             i_valid,
  input  wire logic [CNT_W-1:0] i_sum,
  input  wire logic             i_pol,
  output sdc_pkg::sdc_filt_t    o_out
);
  import sdc_pkg::*;

  localparam int W_W  = CNT_W + 2;
  localparam int SC_W = W_W + SHIFT;

  logic [CNT_W-1:0] p1_reg;
  logic [CNT_W-1:0] p2_reg;
  logic [1:0]       fill_reg;
  logic [W_W-1:0]   wsum;
  logic [SC_W-1:0]  scaled;
  logic             clip;
  logic [RES_W-1:0] sat;

  // Weights 1-2-1 over the last three periods
  assign wsum   = W_W'(i_sum) + {1'b0, p1_reg, 1'b0} + W_W'(p2_reg);
  assign scaled = {wsum, {SHIFT{1'b0}}};
  assign clip   = |scaled[SC_W-1:RES_W];
  assign sat    = clip ? {RES_W{1'b1}} : scaled[RES_W-1:0];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      p1_reg   <= '0;
      p2_reg   <= '0;
      fill_reg <= '0;
    end else if (i_clear) begin
      p1_reg   <= '0;
      p2_reg   <= '0;
      fill_reg <= '0;
    end else if (i_valid) begin
      p1_reg <= i_sum;
      p2_reg <= p1_reg;
      if (fill_reg != SLOW_FILL) begin
        fill_reg <= fill_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out <= '0;
    end else begin
      o_out.valid <= i_valid & ~i_clear & (fill_reg == SLOW_FILL);
      if (i_valid && !i_clear && fill_reg == SLOW_FILL) begin
        o_out.clip <= clip;
        o_out.data <= i_pol ? (sat ^ SIGN_BIT) : sat;
      end
    end
  end

endmodule : sdc_sinc3_filter

// *** sdc_monitor.sv ***
// Port-level timing checker for the sigma-delta conversion control block
`timescale 1ns/1ps
module sdc_monitor
  import sdc_pkg::*;
(
  input wire logic               i_clk,
  input wire logic               i_arst_n,
  input wire logic [ADDR_W-1:0]  i_addr,
  input wire logic [DATA_W-1:0]  i_wdata,
  input wire logic               i_wr,
  input wire logic               o_busy,
  input wire logic               o_done,
  input wire logic               o_burnout_en,
  input wire logic               o_dac_load
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_dac_load_pulse: assert property (i_wr && i_addr == A_DAC && !o_busy
    |-> ##[1:2] o_dac_load) else $error("offset DAC write gave no load pulse");
  a_dac_load_cause: assert property ($rose(o_dac_load)
    |-> ($past(i_wr) && $past(i_addr) == A_DAC) || ($past(i_wr, 2) && $past(i_addr, 2) == A_DAC))
    else $error("DAC load pulse without a DAC write");
  a_busy_on_start: assert property (i_wr && i_addr == A_MODE && !o_busy && i_wdata[7]
    && i_wdata[2:1] == 2'b01 |-> ##[1:2] o_busy) else $error("conversion start gave no busy");
  a_done_stays_set: assert property (o_done && !(i_wr && i_addr == A_STAT)
    |=> o_done) else $error("done flag dropped without a status write");
  a_done_from_conv: assert property ($rose(o_done) |-> $past(o_busy))
    else $error("done flag rose with no conversion running");
  a_burnout_on: assert property (i_wr && i_addr == A_CTRL && !o_busy && i_wdata[3]
    |-> ##[1:2] o_burnout_en) else $error("burnout sources not switched on");
  a_burnout_off: assert property (i_wr && i_addr == A_CTRL && !o_busy && !i_wdata[3]
    |-> ##[1:2] !o_burnout_en) else $error("burnout sources not switched off");
  a_stop_to_idle: assert property (i_wr && i_addr == A_MODE
    && (!i_wdata[7] || i_wdata[2:0] == 3'b000) |-> ##[1:2] !o_busy)
    else $error("idle mode write left the converter busy");
endmodule : sdc_monitor

bind sdc_top sdc_monitor u_mon (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .o_busy(o_busy), .o_done(o_done),
  .o_burnout_en(o_burnout_en), .o_dac_load(o_dac_load));

// *** tb.sv ***
// Self-checking bench for the sigma-delta conversion control block
`timescale 1ns/1ps
module tb;
  import sdc_pkg::*;
  logic              i_clk      = 1'b0;
  logic              i_arst_n   = 1'b0;
  logic [ADDR_W-1:0] i_addr     = '0;
  logic [DATA_W-1:0] i_wdata    = '0;
  logic              i_wr       = 1'b0;
  logic              i_rd       = 1'b0;
  logic              i_mod_data = 1'b0;
  logic              i_cal_err  = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic              o_busy, o_done, o_adc_en, o_burnout_en, o_vref_ext, o_dac_load;
  logic [2:0]        o_pga_gain;
  sdc_dac_t          o_dac;
  int                n_errors    = 0;
  int                comparisons = 0;
  int                n;

  always #4 i_clk = ~i_clk;

  sdc_top uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mod_data(i_mod_data),
    .i_cal_err(i_cal_err), .o_busy(o_busy), .o_done(o_done), .o_adc_en(o_adc_en),
    .o_burnout_en(o_burnout_en), .o_pga_gain(o_pga_gain), .o_vref_ext(o_vref_ext),
    .o_dac(o_dac), .o_dac_load(o_dac_load));

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string w);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h expected %h", $time, w, got, exp);
    end
  endtask : chk_val

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the read edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp, input string w);
    logic [7:0] d;
    rd(a, d);
    chk_val({16'h0000, d}, {16'h0000, exp}, w);
  endtask : chk_reg

  task automatic chk_res(input logic [3:0] a, input logic [23:0] exp, input string w);
    logic [7:0] h, m, l;
    rd(a, h);
    rd(a + 4'h1, m);
    rd(a + 4'h2, l);
    chk_val({h, m, l}, exp, w);
  endtask : chk_res

  // Bounded so a missing done flag cannot hang the run
  task automatic wait_done(output int c);
    c = 0;
    while (o_done !== 1'b1 && c < 20000) begin
      cyc(1);
      c++;
    end
  endtask : wait_done

  task automatic t_regs();
    chk_reg(A_CTRL, 8'h10, "ctrl reset");
    chk_reg(A_DECH, 8'h07, "decimation high reset");
    chk_reg(A_DAC, 8'h00, "dac reset");
    wr(4'hF, 8'hFF);
    chk_reg(4'hF, 8'h00, "unmapped read");
    wr(A_DAC, 8'h85);
    n = 0;
    #1;
    // The load pulse stands only in the cycle right after the write edge
    repeat (3) begin
      n += int'(o_dac_load === 1'b1);
      cyc(1);
    end
    chk_val(n[23:0], 24'h000001, "dac load pulses");
    chk_val({16'h0000, o_dac}, 24'h000085, "dac sign magnitude");
    wr(A_CTRL, 8'h0D);
    wr(A_CFG, 8'h04);
    cyc(2);
    chk_val({20'h0, o_burnout_en, o_pga_gain}, 24'h00000D, "burnout on and gain");
    chk_val({23'h0, o_vref_ext}, 24'h000001, "external reference");
    wr(A_CTRL, 8'h00);
    cyc(2);
    chk_val({23'h0, o_burnout_en}, 24'h000000, "burnout off");
  endtask : t_regs

  // Decimation 19 gives 20 ticks of 128 clocks a period
  task automatic t_single_fast();
    wr(A_CFG, 8'h10);
    i_mod_data <= 1'b1;
    wr(A_DECH, 8'h00);
    wr(A_DECL, 8'h00);
    wr(A_MODE, 8'h82);
    cyc(3);
    chk_val({22'h0, o_adc_en, o_busy}, 24'h000003, "enabled and busy in single");
    wait_done(n);
    chk_val({23'h0, n >= 2530 && n <= 2620}, 24'h000001, "fast period");
    chk_val({23'h0, o_busy}, 24'h000000, "busy after single");
    chk_reg(A_MODE, 8'h80, "mode back to idle");
    chk_reg(A_STAT, 8'h01, "done on fast");
    chk_res(A_FAST_H, 24'h028000, "fast unipolar");
    wr(A_STAT, 8'h00);
    cyc(1);
    chk_val({23'h0, o_done}, 24'h000000, "done cleared");
  endtask : t_single_fast

  task automatic t_single_slow();
    wr(A_CTRL, 8'h10);
    i_mod_data <= 1'b0;
    wr(A_CFG, 8'h00);
    wr(A_MODE, 8'h82);
    cyc(5300);
    chk_val({22'h0, o_busy, o_done}, 24'h000002, "slow not yet done");
    wait_done(n);
    chk_val({23'h0, n >= 2330 && n <= 2440}, 24'h000001, "three periods");
    chk_val({23'h0, o_busy}, 24'h000000, "busy after slow");
    chk_res(A_SLOW_H, 24'h800000, "slow bipolar");
    chk_res(A_FAST_H, 24'h800000, "fast in slow single");
    wr(A_STAT, 8'h00);
  endtask : t_single_slow

  task automatic t_cont();
    wr(A_CTRL, 8'h00);
    i_mod_data <= 1'b1;
    wr(A_CFG, 8'h10);
    wr(A_MODE, 8'h83);
    wait_done(n);
    wr(A_CTRL, 8'h08);
    cyc(5200);
    chk_reg(A_STAT, 8'h87, "overrun while running");
    chk_val({23'h0, o_burnout_en}, 24'h000000, "ctrl locked busy");
    chk_res(A_SLOW_H, 24'h028000, "slow in continuous");
    chk_res(A_FAST_H, 24'h028000, "fast overwritten");
    wr(A_MODE, 8'h80);
    cyc(2);
    chk_val({23'h0, o_busy}, 24'h000000, "continuous stopped");
    wr(A_STAT, 8'h00);
    chk_reg(A_STAT, 8'h00, "status cleared");
  endtask : t_cont

  task automatic t_abort_cal();
    wr(A_MODE, 8'h82);
    cyc(100);
    wr(A_MODE, 8'h80);
    cyc(2);
    chk_val({22'h0, o_busy, o_done}, 24'h000000, "aborted single");
    @(posedge i_clk);
    i_cal_err <= 1'b1;
    @(posedge i_clk);
    i_cal_err <= 1'b0;
    chk_reg(A_STAT, 8'h02, "calibration limit");
    wr(A_STAT, 8'h00);
    wr(A_MODE, 8'h81);
    cyc(3);
    chk_val({23'h0, o_busy}, 24'h000000, "calibration code starts no conversion");
    wr(A_MODE, 8'h02);
    chk_reg(A_MODE, 8'h00, "disable forces idle code");
  endtask : t_abort_cal

  initial begin
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_regs();
    t_single_fast();
    t_single_slow();
    t_cont();
    t_abort_cal();
    print_verdict();
  end

  // Whole run needs about 18300 cycles
  initial begin
    repeat (40000) @(posedge i_clk);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : tb
